// ===== verilog/pic_top.sv
// Prioritized interrupt controller with APB register access
//
// How it works
// - Enable bit 2 of second extended enable gates wake-up timer.
// - Enable bit 1 of second extended enable gates timer 3 overflow.
// - Enable bit 0 gates serial 1; tx-done or rx-done requests.
// - Each source level is high bit and low bit, 0 lowest to 3.
// - Only a strictly higher level preempts the handler in service.
// - Returns unwind nested handlers back down to the main program.
// - Natural order never lets an equal level preempt.
// - Level-0 request vectors only when nothing is in service.
// - Highest level wins; equal levels resolved by natural order.
// - Natural order external 0 first through wake-up timer last.
// - Each source has its fixed vector address.
// - Only six listed sources may wake from power-down.
// - Edge-triggered external flag clears when its routine is vectored.
// - Level-triggered external flag follows inverted pin, no writes.
// - Timer 0, 1, 3 flags clear on vectoring; timer 2 does not.
// - Level pin-interrupt channel flag shows channel state, no writes.
// - Primary low priority register holds seven low level bits.
// - Primary high priority register holds matching high level bits.
// - Cleared global enable blocks vectoring of all sources, not wake-up; flags stay pending.
// - Flags sampled and priority resolved every cycle, nothing latched.
`timescale 1ns/1ps
`default_nettype none
`include "pic_consts.svh"
module pic_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [11:0]                paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic                            pready_o,
  output logic                            pslverr_o,
  output logic [31:0]                     prdata_o,
  input  wire logic [1:0]                 ext_pin_i,
  input  wire logic [2:0]                 timer_ovf_i,
  input  wire logic [7:0]                 pin_edge_i,
  input  wire logic [7:0]                 pin_state_i,
  input  wire pic_pkg::pic_periph_flags_t periph_flags_i,
  input  wire logic                       cpu_poll_ok_i,
  input  wire logic                       return_from_interrupt_i,
  output logic                            call_o,
  output pic_pkg::pic_call_t              call_info_o,
  output logic                            wakeup_o
);
  logic [7:0]  en_pri, en_ext, extra_enable_second;
  logic [7:0]  priority_low_primary, priority_high_primary;
  logic [7:0]  plo_ext, phi_ext, plo_ext2, phi_ext2;
  logic [7:0]  trigger, pin_mode, pin_irq_flags;
  logic [1:0]  ext_s1, ext_s2, ext_s3, ext_flag;
  logic [2:0]  timer_flag;
  logic [3:0]  in_service;
  logic [17:0] flg, en, lo, hi, pend;
  logic [35:0] lvl;
  logic        global_irq_en;
  logic        best_valid, allowed, take;
  logic        wr, rd_setup;
  logic [7:0]  idx;
  logic [7:0]  rd_val;
  logic [3:0]  next_in_service;
  pic_pkg::pic_src_t best_src;
  pic_pkg::pic_lvl_t best_lvl, cur_lvl;

  // Spread three registers of one layout into natural-order source bits
  function automatic logic [17:0] to_src(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] c);
    logic [17:0] r;
    r = '0;
    r[`PIC_SRC_EXT0] = a[`PIC_BIT_EXT0];
    r[`PIC_SRC_BOD]  = a[`PIC_BIT_BOD];
    r[`PIC_SRC_WDT]  = b[`PIC_BIT_WDT];
    r[`PIC_SRC_T0]   = a[`PIC_BIT_T0];
    r[`PIC_SRC_I2C]  = b[`PIC_BIT_I2C];
    r[`PIC_SRC_ADC]  = a[`PIC_BIT_ADC];
    r[`PIC_SRC_EXT1] = a[`PIC_BIT_EXT1];
    r[`PIC_SRC_PIN]  = b[`PIC_BIT_PIN];
    r[`PIC_SRC_T1]   = a[`PIC_BIT_T1];
    r[`PIC_SRC_S0]   = a[`PIC_BIT_S0];
    r[`PIC_SRC_FB]   = b[`PIC_BIT_FB];
    r[`PIC_SRC_SPI]  = b[`PIC_BIT_SPI];
    r[`PIC_SRC_T2]   = b[`PIC_BIT_T2];
    r[`PIC_SRC_CAP]  = b[`PIC_BIT_CAP];
    r[`PIC_SRC_PWM]  = b[`PIC_BIT_PWM];
    r[`PIC_SRC_S1]   = c[`PIC_BIT_S1];
    r[`PIC_SRC_T3]   = c[`PIC_BIT_T3];
    r[`PIC_SRC_WKT]  = c[`PIC_BIT_WKT];
    return r;
  endfunction : to_src

  function automatic logic [15:0] vec_of(input pic_pkg::pic_src_t s);
    logic [15:0] v;
    v = '0;
    unique case (s)
      `PIC_SRC_EXT0: v = `PIC_VEC_EXT0;
      `PIC_SRC_BOD:  v = `PIC_VEC_BOD;
      `PIC_SRC_WDT:  v = `PIC_VEC_WDT;
      `PIC_SRC_T0:   v = `PIC_VEC_T0;
      `PIC_SRC_I2C:  v = `PIC_VEC_I2C;
      `PIC_SRC_ADC:  v = `PIC_VEC_ADC;
      `PIC_SRC_EXT1: v = `PIC_VEC_EXT1;
      `PIC_SRC_PIN:  v = `PIC_VEC_PIN;
      `PIC_SRC_T1:   v = `PIC_VEC_T1;
      `PIC_SRC_S0:   v = `PIC_VEC_S0;
      `PIC_SRC_FB:   v = `PIC_VEC_FB;
      `PIC_SRC_SPI:  v = `PIC_VEC_SPI;
      `PIC_SRC_T2:   v = `PIC_VEC_T2;
      `PIC_SRC_CAP:  v = `PIC_VEC_CAP;
      `PIC_SRC_PWM:  v = `PIC_VEC_PWM;
      `PIC_SRC_S1:   v = `PIC_VEC_S1;
      `PIC_SRC_T3:   v = `PIC_VEC_T3;
      `PIC_SRC_WKT:  v = `PIC_VEC_WKT;
      default:       v = '0;
    endcase
    return v;
  endfunction : vec_of

  function automatic logic is_mapped(input logic [7:0] i);
    return i inside {`PIC_IDX_EN_PRI, `PIC_IDX_EN_EXT, `PIC_IDX_EN_EXT2,
                     `PIC_IDX_PLO_PRI, `PIC_IDX_PHI_PRI, `PIC_IDX_PLO_EXT,
                     `PIC_IDX_PHI_EXT, `PIC_IDX_PLO_EXT2,
                     `PIC_IDX_PHI_EXT2, `PIC_IDX_FLAGS, `PIC_IDX_TRIGGER,
                     `PIC_IDX_PIN_MODE, `PIC_IDX_PIN_FLAGS,
                     `PIC_IDX_IN_SERVICE};
  endfunction : is_mapped

  // APB slave: zero wait states, error on an unmapped or high address
  assign idx       = paddr_i[9:2];
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i &
                     ((paddr_i[11:10] != 2'b00) | ~is_mapped(idx));
  assign wr        = psel_i & penable_i & pwrite_i & ~pslverr_o;
  assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      en_pri                <= `PIC_RESET_VAL;
      en_ext                <= `PIC_RESET_VAL;
      extra_enable_second   <= `PIC_RESET_VAL;
      priority_low_primary  <= `PIC_RESET_VAL;
      priority_high_primary <= `PIC_RESET_VAL;
      plo_ext               <= `PIC_RESET_VAL;
      phi_ext               <= `PIC_RESET_VAL;
      plo_ext2              <= `PIC_RESET_VAL;
      phi_ext2              <= `PIC_RESET_VAL;
      trigger               <= `PIC_RESET_VAL;
      pin_mode              <= `PIC_RESET_VAL;
    end else if (wr) begin
      unique case (idx)
        `PIC_IDX_EN_PRI:   en_pri <= pwdata_i[7:0];
        `PIC_IDX_EN_EXT:   en_ext <= pwdata_i[7:0];
        `PIC_IDX_EN_EXT2:  extra_enable_second <= pwdata_i[7:0] &
                                                  `PIC_MASK_EXT2;
        `PIC_IDX_PLO_PRI:  priority_low_primary <= pwdata_i[7:0] &
                                                   `PIC_MASK_PRI;
        `PIC_IDX_PHI_PRI:  priority_high_primary <= pwdata_i[7:0] &
                                                    `PIC_MASK_PRI;
        `PIC_IDX_PLO_EXT:  plo_ext <= pwdata_i[7:0];
        `PIC_IDX_PHI_EXT:  phi_ext <= pwdata_i[7:0];
        `PIC_IDX_PLO_EXT2: plo_ext2 <= pwdata_i[7:0] & `PIC_MASK_EXT2;
        `PIC_IDX_PHI_EXT2: phi_ext2 <= pwdata_i[7:0] & `PIC_MASK_EXT2;
        `PIC_IDX_TRIGGER:  trigger <= pwdata_i[7:0] & `PIC_MASK_TRIGGER;
        `PIC_IDX_PIN_MODE: pin_mode <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (idx)
      `PIC_IDX_EN_PRI:     rd_val = en_pri;
      `PIC_IDX_EN_EXT:     rd_val = en_ext;
      `PIC_IDX_EN_EXT2:    rd_val = extra_enable_second;
      `PIC_IDX_PLO_PRI:    rd_val = priority_low_primary;
      `PIC_IDX_PHI_PRI:    rd_val = priority_high_primary;
      `PIC_IDX_PLO_EXT:    rd_val = plo_ext;
      `PIC_IDX_PHI_EXT:    rd_val = phi_ext;
      `PIC_IDX_PLO_EXT2:   rd_val = plo_ext2;
      `PIC_IDX_PHI_EXT2:   rd_val = phi_ext2;
      `PIC_IDX_FLAGS:      rd_val = {3'h0, timer_flag, ext_flag};
      `PIC_IDX_TRIGGER:    rd_val = trigger;
      `PIC_IDX_PIN_MODE:   rd_val = pin_mode;
      `PIC_IDX_PIN_FLAGS:  rd_val = pin_irq_flags;
      `PIC_IDX_IN_SERVICE: rd_val = {4'h0, in_service};
      default:             rd_val = 8'h00;
    endcase
  end

  // Read data is caught in the setup cycle and stands through the access
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= {24'h00_0000, rd_val};
    end
  end

  // External pins: two flops before use, a third only for edge compare
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ext_s1 <= 2'h3;
      ext_s2 <= 2'h3;
      ext_s3 <= 2'h3;
    end else begin
      ext_s1 <= ext_pin_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ext
    localparam pic_pkg::pic_src_t SRC = (g == 0) ? `PIC_SRC_EXT0
                                                 : `PIC_SRC_EXT1;
    localparam int FB = (g == 0) ? `PIC_FLG_EXT0 : `PIC_FLG_EXT1;
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        ext_flag[g] <= 1'b0;
      end else if (!trigger[g]) begin
        ext_flag[g] <= ~ext_s2[g];
      end else if (ext_s3[g] & ~ext_s2[g]) begin
        ext_flag[g] <= 1'b1;
      end else if (take && best_src == SRC) begin
        ext_flag[g] <= 1'b0;
      end else if (wr && idx == `PIC_IDX_FLAGS) begin
        ext_flag[g] <= pwdata_i[FB];
      end
    end
  end

  // Timer 0, 1 and 3 flags; timer 2 stays with its own peripheral
  for (genvar g = 0; g < 3; g++) begin : g_tmr
    localparam pic_pkg::pic_src_t SRC = (g == 0) ? `PIC_SRC_T0 :
                                        (g == 1) ? `PIC_SRC_T1 : `PIC_SRC_T3;
    localparam int FB = (g == 0) ? `PIC_FLG_T0 :
                        (g == 1) ? `PIC_FLG_T1 : `PIC_FLG_T3;
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        timer_flag[g] <= 1'b0;
      end else if (timer_ovf_i[g]) begin
        timer_flag[g] <= 1'b1;
      end else if (take && best_src == SRC) begin
        timer_flag[g] <= 1'b0;
      end else if (wr && idx == `PIC_IDX_FLAGS) begin
        timer_flag[g] <= pwdata_i[FB];
      end
    end
  end

  // Level channels mirror state; edge channels set wins over a write
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_irq_flags <= `PIC_RESET_VAL;
    end else begin
      pin_irq_flags <= (pin_mode & pin_state_i) |
                       (~pin_mode & (pin_edge_i |
                        ((wr && idx == `PIC_IDX_PIN_FLAGS) ?
                         pwdata_i[7:0] : pin_irq_flags)));
    end
  end

  always_comb begin
    flg = '0;
    flg[`PIC_SRC_EXT0] = ext_flag[0];
    flg[`PIC_SRC_BOD]  = periph_flags_i.brownout;
    flg[`PIC_SRC_WDT]  = periph_flags_i.watchdog;
    flg[`PIC_SRC_T0]   = timer_flag[0];
    flg[`PIC_SRC_I2C]  = periph_flags_i.two_wire;
    flg[`PIC_SRC_ADC]  = periph_flags_i.converter;
    flg[`PIC_SRC_EXT1] = ext_flag[1];
    flg[`PIC_SRC_PIN]  = |pin_irq_flags;
    flg[`PIC_SRC_T1]   = timer_flag[1];
    flg[`PIC_SRC_S0]   = periph_flags_i.serial0;
    flg[`PIC_SRC_FB]   = periph_flags_i.fault_brake;
    flg[`PIC_SRC_SPI]  = periph_flags_i.serial_periph;
    flg[`PIC_SRC_T2]   = periph_flags_i.timer2_event_flag;
    flg[`PIC_SRC_CAP]  = periph_flags_i.capture;
    flg[`PIC_SRC_PWM]  = periph_flags_i.pulse_width;
    flg[`PIC_SRC_S1]   = periph_flags_i.serial1_tx_done_flag |
                         periph_flags_i.serial1_rx_done_flag;
    flg[`PIC_SRC_T3]   = timer_flag[2];
    flg[`PIC_SRC_WKT]  = periph_flags_i.wakeup_timer_flag;
  end

  // Requests are recomputed every cycle from live flags, never latched
  assign global_irq_en = en_pri[`PIC_BIT_EA];
  assign en   = to_src(en_pri, en_ext, extra_enable_second);
  assign lo   = to_src(priority_low_primary, plo_ext, plo_ext2);
  assign hi   = to_src(priority_high_primary, phi_ext, phi_ext2);
  assign pend = flg & en & {18{global_irq_en}};
  for (genvar s = 0; s < `PIC_N_SRC; s++) begin : g_lvl
    assign lvl[2*s +: 2] = {hi[s], lo[s]};
  end

  pic_arbiter #(
    .N_SRC (`PIC_N_SRC)
  ) u_arbiter (
    .pend_i  (pend),
    .lvl_i   (lvl),
    .valid_o (best_valid),
    .src_o   (best_src),
    .lvl_o   (best_lvl)
  );

  // Wake needs only the individual enable: the core is stopped anyway
  assign wakeup_o = |(flg & en & `PIC_WAKE_MASK);

  always_comb begin
    cur_lvl = '0;
    for (int l = 0; l < 4; l++) begin
      if (in_service[l]) begin
        cur_lvl = pic_pkg::pic_lvl_t'(l);
      end
    end
  end

  // Strictly higher than the highest marker, or nothing in service
  assign allowed = best_valid &&
                   (in_service == 4'h0 || best_lvl > cur_lvl);
  assign take    = allowed & cpu_poll_ok_i;

  always_comb begin
    next_in_service = in_service;
    if (return_from_interrupt_i) begin
      next_in_service[cur_lvl] = 1'b0;
    end
    if (take) begin
      next_in_service[best_lvl] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      call_o      <= 1'b0;
      call_info_o <= '0;
    end else begin
      call_o <= take;
      if (take) begin
        call_info_o <= '{vector: vec_of(best_src), src: best_src,
                         lvl: best_lvl};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_take_of(pic_pkg::pic_src_t s);
    take && best_src == s;
  endsequence

  chk_wkt_gate: assert property (s_take_of(`PIC_SRC_WKT) |->
    extra_enable_second[`PIC_BIT_WKT]) else $error("wake-up timer ungated");
  chk_t3_gate: assert property (s_take_of(`PIC_SRC_T3) |->
    extra_enable_second[`PIC_BIT_T3]) else $error("timer 3 ungated");
  chk_s1_gate: assert property (s_take_of(`PIC_SRC_S1) |->
    extra_enable_second[`PIC_BIT_S1]) else $error("serial 1 ungated");
  chk_strict_preempt: assert property (take && $past(in_service) ==
    in_service && in_service != 4'h0 |-> best_lvl > cur_lvl)
    else $error("preempted by equal or lower level");
  chk_low_idle: assert property (take && best_lvl == 2'h0 |->
    in_service == 4'h0) else $error("level 0 vectored while busy");
  chk_global_block: assert property (!global_irq_en |-> !take)
    else $error("vectored with global enable off");
  chk_vector_map: assert property (s_take_of(`PIC_SRC_WKT) |=>
    call_o && call_info_o.vector == `PIC_VEC_WKT) else $error("bad vector");
  chk_marker_set: assert property (take && !return_from_interrupt_i |=>
    in_service[$past(best_lvl)] && call_o) else $error("marker not set");
  chk_return_pop: assert property (return_from_interrupt_i && !take &&
    $countones(in_service) == 2 |=> $countones(in_service) == 1)
    else $error("return did not resume lower handler");
  chk_timer_clear: assert property (s_take_of(`PIC_SRC_T0) ##0
    !timer_ovf_i[0] |=> !timer_flag[0]) else $error("timer 0 flag kept");
  chk_t3_clear: assert property (s_take_of(`PIC_SRC_T3) ##0
    !timer_ovf_i[2] |=> !timer_flag[2]) else $error("timer 3 flag kept");
  chk_tie_order: assert property (take |->
    !(|(pend & ((18'h1 << best_src) - 18'h1) & ~hi & ~lo)) || best_lvl != 2'h0)
    else $error("natural order ignored at level 0");
endmodule : pic_top
`default_nettype wire

// ===== verilog/pic_consts.svh
// Register indices, field positions, source order and vector addresses
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

`define PIC_IDX_EN_PRI      8'hA8
`define PIC_IDX_EN_EXT      8'h9B
`define PIC_IDX_EN_EXT2     8'h9C
`define PIC_IDX_PLO_PRI     8'hB8
`define PIC_IDX_PHI_PRI     8'hB7
`define PIC_IDX_PLO_EXT     8'hEF
`define PIC_IDX_PHI_EXT     8'hF7
`define PIC_IDX_PLO_EXT2    8'hFE
`define PIC_IDX_PHI_EXT2    8'hFF
`define PIC_IDX_FLAGS       8'h01
`define PIC_IDX_TRIGGER     8'h02
`define PIC_IDX_PIN_MODE    8'h03
`define PIC_IDX_PIN_FLAGS   8'h04
`define PIC_IDX_IN_SERVICE  8'h05
`define PIC_RESET_VAL       8'h00
`define PIC_MASK_PRI        8'h7F
`define PIC_MASK_EXT2       8'h07
`define PIC_MASK_FLAGS      8'h1F
`define PIC_MASK_TRIGGER    8'h03

`define PIC_BIT_EXT0  0
`define PIC_BIT_T0    1
`define PIC_BIT_EXT1  2
`define PIC_BIT_T1    3
`define PIC_BIT_S0    4
`define PIC_BIT_BOD   5
`define PIC_BIT_ADC   6
`define PIC_BIT_EA    7
`define PIC_BIT_I2C   0
`define PIC_BIT_PIN   1
`define PIC_BIT_CAP   2
`define PIC_BIT_PWM   3
`define PIC_BIT_WDT   4
`define PIC_BIT_FB    5
`define PIC_BIT_SPI   6
`define PIC_BIT_T2    7
`define PIC_BIT_S1    0
`define PIC_BIT_T3    1
`define PIC_BIT_WKT   2
`define PIC_FLG_EXT0  0
`define PIC_FLG_EXT1  1
`define PIC_FLG_T0    2
`define PIC_FLG_T1    3
`define PIC_FLG_T3    4

`define PIC_N_SRC     18
`define PIC_SRC_EXT0  5'h00
`define PIC_SRC_BOD   5'h01
`define PIC_SRC_WDT   5'h02
`define PIC_SRC_T0    5'h03
`define PIC_SRC_I2C   5'h04
`define PIC_SRC_ADC   5'h05
`define PIC_SRC_EXT1  5'h06
`define PIC_SRC_PIN   5'h07
`define PIC_SRC_T1    5'h08
`define PIC_SRC_S0    5'h09
`define PIC_SRC_FB    5'h0A
`define PIC_SRC_SPI   5'h0B
`define PIC_SRC_T2    5'h0C
`define PIC_SRC_CAP   5'h0D
`define PIC_SRC_PWM   5'h0E
`define PIC_SRC_S1    5'h0F
`define PIC_SRC_T3    5'h10
`define PIC_SRC_WKT   5'h11
`define PIC_WAKE_MASK 18'h200C7

`define PIC_VEC_EXT0  16'h0003
`define PIC_VEC_T0    16'h000B
`define PIC_VEC_EXT1  16'h0013
`define PIC_VEC_T1    16'h001B
`define PIC_VEC_S0    16'h0023
`define PIC_VEC_T2    16'h002B
`define PIC_VEC_I2C   16'h0033
`define PIC_VEC_PIN   16'h003B
`define PIC_VEC_BOD   16'h0043
`define PIC_VEC_SPI   16'h004B
`define PIC_VEC_WDT   16'h0053
`define PIC_VEC_ADC   16'h005B
`define PIC_VEC_CAP   16'h0063
`define PIC_VEC_PWM   16'h006B
`define PIC_VEC_FB    16'h0073
`define PIC_VEC_S1    16'h007B
`define PIC_VEC_T3    16'h0083
`define PIC_VEC_WKT   16'h008B

`endif

// ===== verilog/pic_pkg.sv
// Types shared by the interrupt controller files
`default_nettype none
package pic_pkg;
  typedef logic [4:0] pic_src_t;
  typedef logic [1:0] pic_lvl_t;

  typedef struct packed {
    logic brownout;
    logic watchdog;
    logic two_wire;
    logic converter;
    logic serial0;
    logic fault_brake;
    logic serial_periph;
    logic timer2_event_flag;
    logic capture;
    logic pulse_width;
    logic serial1_tx_done_flag;
    logic serial1_rx_done_flag;
    logic wakeup_timer_flag;
  } pic_periph_flags_t;

  typedef struct packed {
    logic [15:0] vector;
    pic_src_t    src;
    pic_lvl_t    lvl;
  } pic_call_t;
endpackage : pic_pkg
`default_nettype wire

// ===== verilog/pic_arbiter.sv
// Picks the pending source with the highest level, ties by natural order
`timescale 1ns/1ps
`default_nettype none
module pic_arbiter #(
  parameter int N_SRC = 18
) (
  input  wire logic [N_SRC-1:0]   pend_i,
  input  wire logic [2*N_SRC-1:0] lvl_i,
  output logic                    valid_o,
  output pic_pkg::pic_src_t       src_o,
  output pic_pkg::pic_lvl_t       lvl_o
);
  // Source numbers travel as five bits, so more than 32 cannot be named
  if (N_SRC < 1 || N_SRC > 32) begin : g_bad_n_src
    $error("pic_arbiter: N_SRC must lie in 1..32");
  end

  // Walk from the highest index down to index 0; >= lets the earlier index win
  always_comb begin
    valid_o = 1'b0;
    src_o   = '0;
    lvl_o   = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pend_i[i] && (!valid_o || lvl_i[2*i +: 2] >= lvl_o)) begin
        valid_o = 1'b1;
        src_o   = pic_pkg::pic_src_t'(i);
        lvl_o   = lvl_i[2*i +: 2];
      end
    end
  end
endmodule : pic_arbiter
`default_nettype wire

// ===== tb/pic_cpu_model.sv
// CPU side model: polling window and return pulses
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic allow_i,
  input  wire logic ret_req_i,
  input  wire logic call_i,
  output logic      poll_ok_o,
  output logic      ret_o
);
  logic [3:0] depth;
  // A return cycle is never a polling cycle
  assign poll_ok_o = allow_i & ~ret_o;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ret_o <= 1'b0;
    end else begin
      // Only a routine really entered is ever returned from
      ret_o <= ret_req_i & ~ret_o & (depth != 4'h0);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      depth <= 4'h0;
    end else begin
      depth <= depth + {3'h0, call_i} - {3'h0, ret_o};
    end
  end
endmodule : pic_cpu_model
`default_nettype wire

// ===== tb/pic_tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pic_tb_top;
  logic clk_i, rst_b_i, psel, penable, pwrite, pready, perr, e;
  logic call, wake, poll_ok, allow, ret_req, ret, g;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] tovf, en, req, lo, hi;
  logic [15:0] v;
  logic [1:0] ext_pin;
  logic [7:0] pin_edge, pin_state;
  pic_pkg::pic_periph_flags_t pf, tmp;
  pic_pkg::pic_call_t ci;
  int errors, samples_checked, seed;

  pic_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(perr),
    .prdata_o(prdata), .ext_pin_i(ext_pin), .timer_ovf_i(tovf),
    .pin_edge_i(pin_edge), .pin_state_i(pin_state), .periph_flags_i(pf),
    .cpu_poll_ok_i(poll_ok), .return_from_interrupt_i(ret),
    .call_o(call), .call_info_o(ci), .wakeup_o(wake));
  pic_cpu_model cpu (.clk_i(clk_i), .rst_b_i(rst_b_i), .allow_i(allow),
    .ret_req_i(ret_req), .call_i(call), .poll_ok_o(poll_ok), .ret_o(ret));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask : rdc

  // Lone winner of the three sources; strict compare keeps natural order
  function automatic logic [15:0] win();
    logic [15:0] r;
    int best;
    r = 16'h0000;
    best = -1;
    for (int i = 0; i < 3; i++) begin
      if (g && en[i] && req[i] && int'({hi[i], lo[i]}) > best) begin
        best = int'({hi[i], lo[i]});
        r = (i == 0) ? 16'h007B : (i == 1) ? 16'h0083 : 16'h008B;
      end
    end
    return r;
  endfunction : win

  task automatic take(output logic [15:0] vec);
    vec = 16'h0000;
    @(posedge clk_i);
    allow <= 1'b1;
    repeat (8) begin
      @(posedge clk_i);
      if (call === 1'b1 && vec === 16'h0000) vec = ci.vector;
    end
    allow <= 1'b0;
  endtask : take

  task automatic retn();
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : retn

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_of_test();
  end

  initial begin
    seed = 32'hC3AA;
    {rst_b_i, psel, penable, pwrite, allow, ret_req} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tovf = 3'h0;
    pf = '0;
    ext_pin = 2'h3;
    pin_edge = 8'h00;
    pin_state = 8'h00;
    errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdc(8'h9C, 8'h00);
    rdc(8'hB7, 8'h00);
    rdc(8'hB8, 8'h00);
    apb(1'b1, 8'hB8, 8'hFF);
    rdc(8'hB8, 8'h7F);
    apb(1'b1, 8'hB7, 8'hFF);
    rdc(8'hB7, 8'h7F);
    apb(1'b0, 8'h40, 8'h00);
    chk({31'h0, e}, 32'h1);
    // Level-triggered external flag follows the inverted pin, writes ignored
    @(posedge clk_i);
    ext_pin <= 2'h2;
    repeat (4) @(posedge clk_i);
    apb(1'b1, 8'h01, 8'h00);
    rdc(8'h01, 8'h01);
    // Edge-triggered: a falling edge sets it, vectoring clears it
    apb(1'b1, 8'h02, 8'h01);
    apb(1'b1, 8'h01, 8'h00);
    apb(1'b1, 8'hA8, 8'h81);
    @(posedge clk_i);
    ext_pin <= 2'h3;
    repeat (4) @(posedge clk_i);
    ext_pin <= 2'h2;
    repeat (4) @(posedge clk_i);
    rdc(8'h01, 8'h01);
    take(v);
    chk({16'h0, v}, 32'h0003);
    rdc(8'h01, 8'h00);
    retn();
    // Level channel mirrors its state; a write of zero clears an edge channel's flag
    apb(1'b1, 8'h03, 8'h01);
    @(posedge clk_i);
    pin_state <= 8'h01;
    pin_edge <= 8'h02;
    @(posedge clk_i);
    pin_edge <= 8'h00;
    rdc(8'h04, 8'h03);
    apb(1'b1, 8'h04, 8'h00);
    rdc(8'h04, 8'h01);
    pin_state <= 8'h00;
    repeat (40) begin
      g = 1'($random(seed));
      en = 3'($random(seed));
      req = 3'($random(seed));
      lo = 3'($random(seed));
      hi = 3'($random(seed));
      apb(1'b1, 8'hA8, {g, 7'h00});
      apb(1'b1, 8'h9C, {5'h00, en});
      apb(1'b1, 8'hFE, {5'h00, lo});
      apb(1'b1, 8'hFF, {5'h00, hi});
      apb(1'b1, 8'h01, 8'h00);
      tmp = pic_pkg::pic_periph_flags_t'($random(seed));
      tmp.wakeup_timer_flag = req[2];
      tmp.serial1_rx_done_flag = req[0] & lo[1];
      tmp.serial1_tx_done_flag = req[0] & ~lo[1];
      @(posedge clk_i);
      pf <= tmp;
      tovf <= {req[1], 2'h0};
      @(posedge clk_i);
      tovf <= 3'h0;
      repeat (3) @(posedge clk_i);
      chk({31'h0, wake}, {31'h0, en[2] & req[2]});
      take(v);
      chk({16'h0, v}, {16'h0, win()});
      pf <= '0;
      if (v !== 16'h0000) retn();
    end
    apb(1'b1, 8'hA8, 8'h80);
    apb(1'b1, 8'h9C, 8'h07);
    apb(1'b1, 8'hFE, 8'h03);
    apb(1'b1, 8'hFF, 8'h04);
    apb(1'b1, 8'h01, 8'h00);
    @(posedge clk_i);
    tovf <= 3'h4;
    @(posedge clk_i);
    tovf <= 3'h0;
    take(v);
    chk({16'h0, v}, 32'h0083);
    rdc(8'h01, 8'h00);
    tmp = '0;
    tmp.serial1_rx_done_flag = 1'b1;
    pf <= tmp;
    take(v);
    chk({16'h0, v}, 32'h0000);
    tmp.wakeup_timer_flag = 1'b1;
    pf <= tmp;
    take(v);
    chk({16'h0, v}, 32'h008B);
    rdc(8'h05, 8'h06);
    tmp.wakeup_timer_flag = 1'b0;
    pf <= tmp;
    retn();
    take(v);
    chk({16'h0, v}, 32'h0000);
    retn();
    rdc(8'h05, 8'h00);
    take(v);
    chk({16'h0, v}, 32'h007B);
    chk({25'h0, ci.src, ci.lvl}, 32'h0000_003D);
    end_of_test();
  end
endmodule : pic_tb_top
`default_nettype wire
